// *** common/fisu_pkg.sv ***
// fast interrupt swap unit: shared constants and types
package fisu_pkg;

  // ----------------------------------------
  // register map of the fast vector pointer
  // ----------------------------------------
  localparam logic [7:0] FVP_HIGH_ADDR = 8'hDA;
  localparam logic [7:0] FVP_LOW_ADDR  = 8'hDB;
  localparam logic [15:0] FVP_RESET    = 16'h0000;

  // ----------------------------------------
  // system mode register fields
  // ----------------------------------------
  localparam int unsigned MODE_GIE_BIT = 0;
  localparam int unsigned MODE_FEN_BIT = 1;
  localparam int unsigned MODE_LVL_LSB = 2;
  localparam int unsigned MODE_LVL_MSB = 4;

  // ----------------------------------------
  // condition register
  // ----------------------------------------
  localparam int unsigned FLAGS_SVC_BIT = 1;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  SVC_MASK      = 8'h02;

  // ----------------------------------------
  // entry timing in core clock cycles
  // ----------------------------------------
  localparam int unsigned FAST_ENTRY_CYCLES = 6;
  localparam int unsigned VECT_ENTRY_CYCLES = 16;
  localparam int unsigned TIMER_W           = 5;
  localparam logic [TIMER_W-1:0] FAST_LOAD  = TIMER_W'(FAST_ENTRY_CYCLES - 1);
  localparam logic [TIMER_W-1:0] VECT_LOAD  = TIMER_W'(VECT_ENTRY_CYCLES - 1);

  // ----------------------------------------
  // entry sequencer states, gray along idle-fast-vect
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FAST = 2'b01,
    ST_VECT = 2'b11
  } fisu_state_e;

endpackage

// *** core/fisu_cycle_timer.sv ***
// fast interrupt swap unit: down counter that times an entry sequence
`timescale 1ns/1ps
`default_nettype none
module fisu_cycle_timer (
  // clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             reset,
  // control
  input  wire logic                             load,
  input  wire logic [fisu_pkg::TIMER_W-1:0]     load_val,
  // status
  output logic      [fisu_pkg::TIMER_W-1:0]     count,
  output logic                                  at_zero
);

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // load wins, otherwise count down and rest at zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign at_zero = (count == '0);

endmodule
`default_nettype wire

// *** core/fisu_fast_swap.sv ***
// fast interrupt swap unit: pointer swap, flag shadow and entry timing
//
// Function
// - fast pointer is two bytes: high at DAH, low at DBH.
// - fast entry takes 6 cycles, ordinary vectored entry 16.
// - fast level comes from system mode bits 4 to 2.
// - fast handling only while system mode bit 1 is one.
// - any of levels 0 to 7 may be chosen for fast handling.
// - fast entry swaps pointer and program counter.
// - fast entry copies flags into an unaddressed shadow register.
// - fast entry sets the fast service status bit.
// - return with status bit set swaps pointer and counter back.
// - fast return restores flags from the shadow register.
// - fast return clears the fast service status bit.
// - status bit is flags bit 1; it blocks interrupts, steers return.
// - no interrupt is accepted unless system mode bit 0 is one.
`timescale 1ns/1ps
`default_nettype none
module fisu_fast_swap (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // register file port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // system mode register contents
  input  wire logic [7:0]  sys_mode,
  // condition register updates from the alu
  input  wire logic        flags_wr,
  input  wire logic [7:0]  flags_wdata,
  output logic      [7:0]  flags,
  // interrupt request logic
  input  wire logic        irq_req,
  input  wire logic [2:0]  irq_level,
  output logic             irq_ack,
  // cpu sequencer
  input  wire logic [15:0] pc_in,
  input  wire logic        ret_req,
  output logic             ret_ack,
  output logic             pc_load,
  output logic      [15:0] pc_out,
  output logic             vect_entry,
  output logic             vect_return,
  output logic             entry_busy,
  output logic             entry_done
);

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  logic [15:0]                   fast_vector_pointer;
  logic [7:0]                    flags_shadow;
  fisu_pkg::fisu_state_e         state;
  fisu_pkg::fisu_state_e         next_state;
  logic                          timer_load;
  logic [fisu_pkg::TIMER_W-1:0]  timer_val;
  logic [fisu_pkg::TIMER_W-1:0]  timer_count;
  logic                          timer_zero;
  logic                          gie;
  logic                          fast_en;
  logic [2:0]                    fast_level;
  logic                          svc_active;
  logic                          take_irq;
  logic                          take_fast;
  logic                          take_vect;
  logic                          take_fret;
  logic                          take_vret;
  logic                          sel_high;
  logic                          sel_low;

  // ----------------------------------------
  // decode of mode fields
  // ----------------------------------------
  assign gie        = sys_mode[fisu_pkg::MODE_GIE_BIT];
  assign fast_en    = sys_mode[fisu_pkg::MODE_FEN_BIT];
  assign fast_level = sys_mode[fisu_pkg::MODE_LVL_MSB:fisu_pkg::MODE_LVL_LSB];
  assign svc_active = flags[fisu_pkg::FLAGS_SVC_BIT];

  // ----------------------------------------
  // acceptance of requests
  // ----------------------------------------
  // return has priority; interrupts blocked by status bit or global off
  assign take_fret = (state == fisu_pkg::ST_IDLE) && ret_req && svc_active;
  assign take_vret = (state == fisu_pkg::ST_IDLE) && ret_req && !svc_active;
  assign take_irq  = (state == fisu_pkg::ST_IDLE) && !ret_req && irq_req
                     && gie && !svc_active;
  assign take_fast = take_irq && fast_en && (irq_level == fast_level);
  assign take_vect = take_irq && !take_fast;
  assign irq_ack   = take_irq;
  assign ret_ack   = take_fret || take_vret;

  // ----------------------------------------
  // register file decode
  // ----------------------------------------
  assign sel_high = (reg_addr == fisu_pkg::FVP_HIGH_ADDR);
  assign sel_low  = (reg_addr == fisu_pkg::FVP_LOW_ADDR);
  assign reg_hit  = sel_high || sel_low;

  // ----------------------------------------
  // fast vector pointer
  // ----------------------------------------
  // swap beats a software write in the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fast_vector_pointer <= fisu_pkg::FVP_RESET;
    end else if (take_fast || take_fret) begin
      fast_vector_pointer <= pc_in;
    end else if (reg_wr && sel_high) begin
      fast_vector_pointer[15:8] <= reg_wdata;
    end else if (reg_wr && sel_low) begin
      fast_vector_pointer[7:0] <= reg_wdata;
    end
  end

  // read data, one cycle after the read strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && sel_high) begin
      reg_rdata <= fast_vector_pointer[15:8];
    end else if (reg_rd && sel_low) begin
      reg_rdata <= fast_vector_pointer[7:0];
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // program counter hand-off
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_load <= 1'b0;
      pc_out  <= 16'h0000;
    end else begin
      pc_load <= take_fast || take_fret;
      if (take_fast || take_fret) begin
        pc_out <= fast_vector_pointer;
      end
    end
  end

  // ----------------------------------------
  // condition register and its shadow
  // ----------------------------------------
  // hardware entry and return beat an alu write in the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flags <= fisu_pkg::FLAGS_RESET;
    end else if (take_fast) begin
      flags <= flags | fisu_pkg::SVC_MASK;
    end else if (take_fret) begin
      flags <= flags_shadow & ~fisu_pkg::SVC_MASK;
    end else if (flags_wr) begin
      flags <= flags_wdata;
    end
  end

  // shadow has no address; only fast entry loads it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flags_shadow <= fisu_pkg::FLAGS_RESET;
    end else if (take_fast) begin
      flags_shadow <= flags;
    end
  end

  // ----------------------------------------
  // ordinary path strobes to the sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vect_entry  <= 1'b0;
      vect_return <= 1'b0;
    end else begin
      vect_entry  <= take_vect;
      vect_return <= take_vret;
    end
  end

  // ----------------------------------------
  // entry sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_val  = fisu_pkg::FAST_LOAD;
    case (state)
      fisu_pkg::ST_IDLE: begin
        if (take_fast) begin
          next_state = fisu_pkg::ST_FAST;
          timer_load = 1'b1;
          timer_val  = fisu_pkg::FAST_LOAD;
        end else if (take_vect) begin
          next_state = fisu_pkg::ST_VECT;
          timer_load = 1'b1;
          timer_val  = fisu_pkg::VECT_LOAD;
        end
      end
      fisu_pkg::ST_FAST, fisu_pkg::ST_VECT: begin
        if (timer_zero) begin
          next_state = fisu_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = fisu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= fisu_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign entry_busy = (state != fisu_pkg::ST_IDLE);
  assign entry_done = entry_busy && timer_zero;

  fisu_cycle_timer u_timer (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .load     (timer_load),
    .load_val (timer_val),
    .count    (timer_count),
    .at_zero  (timer_zero)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence fast_taken_s;
    irq_ack && fast_en && (irq_level == fast_level);
  endsequence

  sequence fast_ret_s;
    ret_ack && svc_active;
  endsequence

  chk_fast_entry_swap: assert property (fast_taken_s |=>
    pc_load && pc_out == $past(fast_vector_pointer) && fast_vector_pointer == $past(pc_in))
    else $error("fast entry did not swap pointer and counter");

  chk_shadow_and_status: assert property (fast_taken_s |=>
    flags_shadow == $past(flags) && svc_active)
    else $error("fast entry did not shadow flags and set status");

  chk_fast_entry_time: assert property (fast_taken_s |=>
    (entry_busy && !entry_done) [*5] ##1 (entry_done && state == fisu_pkg::ST_FAST))
    else $error("fast entry did not finish in six cycles");

  chk_vect_entry_time: assert property (irq_ack && !take_fast |=>
    vect_entry ##15 (entry_done && state == fisu_pkg::ST_VECT))
    else $error("vectored entry did not finish in sixteen cycles");

  chk_fast_return: assert property (fast_ret_s |=>
    pc_load && pc_out == $past(fast_vector_pointer) && fast_vector_pointer == $past(pc_in)
    && flags == ($past(flags_shadow) & ~fisu_pkg::SVC_MASK) && !vect_return)
    else $error("fast return did not swap back and restore flags");

  chk_no_irq_global_off: assert property (!gie |-> !irq_ack)
    else $error("interrupt taken with global enable off");

  chk_status_inhibit: assert property (svc_active |-> !irq_ack ##1
    !(irq_ack && !svc_active && $past(svc_active) && !$past(ret_ack)))
    else $error("interrupt taken while fast service active");

  chk_level_routing: assert property (irq_ack |=>
    (state == fisu_pkg::ST_FAST) == $past(fast_en && irq_level == fast_level))
    else $error("interrupt routed to wrong entry path");

  chk_pointer_reload: assert property (reg_wr && sel_low && !take_fast && !take_fret |=>
    fast_vector_pointer[7:0] == $past(reg_wdata)
    && fast_vector_pointer[15:8] == $past(fast_vector_pointer[15:8]))
    else $error("low pointer byte write misplaced");

endmodule
`default_nettype wire

// *** tb/fisu_seq_model.sv ***
// sequencer and request logic model facing the fast swap unit
`timescale 1ns/1ps
`default_nettype none
module fisu_seq_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // commands from the bench
  input  wire logic        go_irq,
  input  wire logic [2:0]  go_lvl,
  input  wire logic        go_ret,
  // unit side
  input  wire logic        irq_ack,
  input  wire logic        ret_ack,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_out,
  output logic             irq_req,
  output logic      [2:0]  irq_level,
  output logic             ret_req,
  output logic      [15:0] pc_in
);
  logic [2:0] lvl_q;

  // interrupt request held until taken
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      irq_req <= 1'b0;
      lvl_q   <= 3'h0;
    end else if (go_irq) begin
      irq_req <= 1'b1;
      lvl_q   <= go_lvl;
    end else if (irq_ack) begin
      irq_req <= 1'b0;
    end
  end

  // return request held until taken
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ret_req <= 1'b0;
    end else if (go_ret) begin
      ret_req <= 1'b1;
    end else if (ret_ack) begin
      ret_req <= 1'b0;
    end
  end

  // program counter runs on, reloads on pc_load
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pc_in <= 16'h4000;
    end else begin
      pc_in <= pc_load ? pc_out : pc_in + 16'h0001;
    end
  end

  // level is meaningless while idle, so it keeps moving
  assign irq_level = irq_req ? lvl_q : pc_in[2:0];
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the fast interrupt swap unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, reset, reg_wr, reg_rd, reg_hit, flags_wr;
  logic        irq_req, irq_ack, ret_req, ret_ack, pc_load, vect_entry;
  logic        vect_return, entry_busy, entry_done, go_irq, go_ret;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, sys_mode, flags_wdata, flags, f;
  logic [2:0]  irq_level, go_lvl;
  logic [15:0] pc_in, pc_out, ptr, ent_pc, ret_pc;
  integer      seed = 32'hB76E;
  int          n_errors = 0;
  int          num_checks = 0;

  fisu_fast_swap fisu_fast_swap_i (.sys_clk, .reset, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_hit, .sys_mode, .flags_wr, .flags_wdata, .flags,
    .irq_req, .irq_level, .irq_ack, .pc_in, .ret_req, .ret_ack, .pc_load, .pc_out,
    .vect_entry, .vect_return, .entry_busy, .entry_done);
  fisu_seq_model fisu_seq_model_i (.sys_clk, .reset, .go_irq, .go_lvl, .go_ret,
    .irq_ack, .ret_ack, .pc_load, .pc_out, .irq_req, .irq_level, .ret_req, .pc_in);

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic test_done();
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    test_done();
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // drivers, all entered just after a rising edge
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(posedge sys_clk); #1 reg_wr = 1'b0;
    @(posedge sys_clk); #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a; reg_rd = 1'b1;
    @(posedge sys_clk); #1 reg_rd = 1'b0;
    chk(reg_rdata, e);
    chk(reg_hit, (a == fisu_pkg::FVP_HIGH_ADDR) || (a == fisu_pkg::FVP_LOW_ADDR));
    @(posedge sys_clk); #1;
  endtask
  task automatic setf(input logic [7:0] v);
    flags_wdata = v; flags_wr = 1'b1;
    @(posedge sys_clk); #1 flags_wr = 1'b0;
  endtask
  task automatic fire(input logic [2:0] l);
    go_lvl = l; go_irq = 1'b1;
    @(posedge sys_clk); #1 go_irq = 1'b0;
  endtask
  // ten cycles in which no request may be taken
  task automatic quiet();
    logic s;
    s = 1'b0;
    repeat (10) begin
      @(posedge sys_clk); #1 s = s | irq_ack;
    end
    chk(s, 16'h0000);
  endtask
  // wait for the acknowledge, then time and check the entry
  task automatic entry(input logic fast, input logic [15:0] p, input logic [7:0] fl);
    int n;
    n = 0;
    while (irq_ack !== 1'b1) begin
      @(negedge sys_clk); n++;
      if (n > 40) hang();
    end
    ent_pc = pc_in;
    n = 0;
    do begin
      @(posedge sys_clk); #1 n++;
      if (n == 1) begin
        chk(pc_load, fast);
        chk(vect_entry, !fast);
        chk(flags, fast ? (fl | fisu_pkg::SVC_MASK) : fl);
        chk(entry_busy, 1'b1);
        if (fast) chk(pc_out, p);
      end
    end while (entry_done !== 1'b1 && n < 40);
    chk(16'(n), fast ? 16'h0006 : 16'h0010);
  endtask
  // return instruction and its outcome
  task automatic ret_instr(input logic fast, input logic [15:0] p, input logic [7:0] fl);
    int n;
    go_ret = 1'b1;
    @(posedge sys_clk); #1 go_ret = 1'b0;
    n = 0;
    while (ret_ack !== 1'b1) begin
      @(negedge sys_clk); n++;
      if (n > 40) hang();
    end
    ret_pc = pc_in;
    @(posedge sys_clk); #1 chk(pc_load, fast);
    chk(vect_return, !fast);
    chk(flags, fl);
    if (fast) chk(pc_out, p);
  endtask

  // ----------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    hang();
  end
  initial begin
    reset = 1'b1; reg_addr = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 8'h00;
    sys_mode = 8'h00; flags_wr = 1'b0; flags_wdata = 8'h00;
    go_irq = 1'b0; go_lvl = 3'h0; go_ret = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    chk(flags, 16'h0000);
    rd(fisu_pkg::FVP_HIGH_ADDR, 8'h00);
    rd(8'hD9, 8'h00);
    // every level through fast entry, blocked, returned and re-entered
    for (int l = 0; l < 8; l++) begin
      ptr = 16'($random(seed));
      f = 8'($random(seed)) & ~fisu_pkg::SVC_MASK;
      wr(fisu_pkg::FVP_HIGH_ADDR, ptr[15:8]);
      wr(fisu_pkg::FVP_LOW_ADDR, ptr[7:0]);
      rd(fisu_pkg::FVP_HIGH_ADDR, ptr[15:8]);
      rd(fisu_pkg::FVP_LOW_ADDR, ptr[7:0]);
      sys_mode = {3'($random(seed)), 3'(l), 2'b00};
      setf(f);
      sys_mode[1] = 1'b1;
      fire(3'(l));
      quiet();
      sys_mode[0] = 1'b1;
      entry(1'b1, ptr, f);
      setf(8'($random(seed)) | fisu_pkg::SVC_MASK);
      fire(3'(l));
      quiet();
      ret_instr(1'b1, ent_pc, f);
      entry(1'b1, ret_pc, f);
      ret_instr(1'b1, ent_pc, f);
      rd(fisu_pkg::FVP_HIGH_ADDR, ret_pc[15:8]);
      rd(fisu_pkg::FVP_LOW_ADDR, ret_pc[7:0]);
    end
    // level other than the selected one, then fast handling off
    sys_mode = 8'h0B;
    fire(3'd5);
    entry(1'b0, ptr, f);
    ret_instr(1'b0, ptr, f);
    sys_mode = 8'h15;
    fire(3'd5);
    entry(1'b0, ptr, f);
    ret_instr(1'b0, ptr, f);
    test_done();
  end
endmodule
`default_nettype wire
